// ==== common/pwm_seq_pkg.sv ====
// Shared constants and carriers for the power-down recovery sequencer.
// Assumes a 20 MHz system clock; all cycle counts derive from its period.
package pwm_seq_pkg;

   // System clock period and the control pin sampling depth.
   localparam int CLK_NS = 50;
   localparam int SYNC_DEPTH = 2;
   // Least spacing, in master clocks, the controller keeps between releases.
   localparam int ORDER_GAP_MCLK = 16;

   // Recovery times in their printed units.
   localparam int LONG_MIN_MS = 85;
   localparam int LONG_MAX_MS = 100;
   localparam int SHORT_MIN_MS = 4;
   localparam int SHORT_MAX_MS = 5;
   localparam int ERR_LOW_MIN_US = 6;
   localparam int ERR_LOW_MAX_US = 47;

   // Cycle counts: least times round up, longest times round down.
   localparam int LONG_CYC = (LONG_MIN_MS * 1000000 + CLK_NS - 1) / CLK_NS;
   localparam int LONG_MAX_CYC = (LONG_MAX_MS * 1000000) / CLK_NS;
   localparam int SHORT_CYC = (SHORT_MIN_MS * 1000000 + CLK_NS - 1) / CLK_NS;
   localparam int ERR_LONG_CYC = (SHORT_MAX_MS * 1000000) / CLK_NS;
   localparam int ERR_LOW_CYC = (ERR_LOW_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int ERR_LOW_MAX_CYC = (ERR_LOW_MAX_US * 1000) / CLK_NS;

   // Width of the recovery delay counter.
   localparam int CNT_W = 21;
   // Width of one captured audio word.
   localparam int SAMPLE_W = 32;

   // Values after reset.
   localparam logic VALID_RST = 1'b0;
   localparam logic MASTER_RST = 1'b0;

   // Control pins from the system controller, all asynchronous.
   typedef struct packed {
      logic dev_reset_n;
      logic power_down_request_n;
      logic error_recovery_request_n;
      logic clock_master_sel;
      logic err_delay_long;
   } ctl_pins_s;

   // One captured audio word with its channel.
   typedef struct packed {
      logic left_ch;
      logic [SAMPLE_W-1:0] data;
   } sample_s;

   // Recovery sequencer states.
   typedef enum logic [2:0] {ST_HELD, ST_ERR_LOW, ST_ERR_HOLD, ST_DELAY, ST_RUN} seq_state_e;

endpackage

// ==== logic/serial_bit_capture.sv ====
// Serial audio capture on the bit clock, with a toggle marking each word.
// Assumes the bit clock may stop between frames; the word stays held.
`timescale 1ns/1ns
`default_nettype none
module serial_bit_capture (
   input wire logic bit_clk_in, // Serial bit clock from the audio source.
   input wire logic resetn_in, // Asynchronous reset, active low.
   input wire logic short_sync_mode_in, // High selects short-sync mode.
   input wire logic serial_audio_input_in, // Serial audio data bit.
   input wire logic frame_sync_in, // Word clock or short frame sync.
   output pwm_seq_pkg::sample_s word_out, // Last completed word.
   output logic word_tog_out // Toggles once per completed word.
);
   import pwm_seq_pkg::*;

   logic mode_meta_r, mode_s_r;
   logic neg_bit_r, neg_fs_r, fs_prev_r, tog_r;
   logic [SAMPLE_W-1:0] shift_r;
   sample_s word_r;

   // Falling edge samples, used only in short-sync mode.
   always_ff @(negedge bit_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         neg_bit_r <= 1'b0;
         neg_fs_r <= 1'b0;
      end else begin
         neg_bit_r <= serial_audio_input_in;
         neg_fs_r <= frame_sync_in;
      end
   end

   // Edge selection and frame boundary decoding.
   wire bit_sel = mode_s_r ? neg_bit_r : serial_audio_input_in;
   wire fs_sel = mode_s_r ? neg_fs_r : frame_sync_in;
   wire boundary = mode_s_r ? (fs_sel & ~fs_prev_r) : (fs_sel ^ fs_prev_r);

   // Rising edge shift register and word latch.
   always_ff @(posedge bit_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mode_meta_r <= 1'b0;
         mode_s_r <= 1'b0;
         fs_prev_r <= 1'b0;
         shift_r <= '0;
         word_r <= '0;
         tog_r <= 1'b0;
      end else begin
         mode_meta_r <= short_sync_mode_in;
         mode_s_r <= mode_meta_r;
         fs_prev_r <= fs_sel;
         shift_r <= {shift_r[SAMPLE_W-2:0], bit_sel};
         if (boundary) begin
            word_r.data <= shift_r;
            word_r.left_ch <= mode_s_r ? ~word_r.left_ch : ~fs_prev_r;
            tog_r <= ~tog_r;
         end
      end
   end

   assign word_out = word_r;
   assign word_tog_out = tog_r;

   // Normal mode takes the bit present at the rising edge.
   property p_rise_capture;
      @(posedge bit_clk_in) disable iff (!resetn_in)
         (!mode_s_r && $stable(mode_s_r)) |=> (shift_r[0] == $past(serial_audio_input_in));
   endproperty
   a_rise_capture: assert property (p_rise_capture) else $error("rising edge bit lost");

   // Short-sync mode takes the bit held since the falling edge.
   property p_fall_capture;
      @(posedge bit_clk_in) disable iff (!resetn_in)
         (mode_s_r && $stable(mode_s_r)) |=> (shift_r[0] == $past(neg_bit_r));
   endproperty
   a_fall_capture: assert property (p_fall_capture) else $error("falling edge bit lost");

endmodule
`default_nettype wire

// ==== logic/pwm_audio_powerdown_recovery_seq.sv ====
// Reset, power-down and error recovery sequencer with serial audio intake.
// Assumes control pins are asynchronous and the bit clock is unrelated.
`timescale 1ns/1ns
`default_nettype none
module pwm_audio_powerdown_recovery_seq #(
   parameter int unsigned LONG_DELAY_CYC = pwm_seq_pkg::LONG_CYC, // Long recovery.
   parameter int unsigned SHORT_DELAY_CYC = pwm_seq_pkg::SHORT_CYC, // Short recovery.
   parameter int unsigned ERR_SHORT_CYC = pwm_seq_pkg::SHORT_CYC, // Error delay, short.
   parameter int unsigned ERR_LONG_CYC = pwm_seq_pkg::ERR_LONG_CYC // Error delay, long.
) (
   input wire logic sys_clk_in, // 20 MHz master clock.
   input wire logic resetn_in, // Asynchronous logic reset, active low.
   input wire pwm_seq_pkg::ctl_pins_s ctl_pins_in, // Controller pins, asynchronous.
   input wire logic bit_clk_in, // Serial bit clock.
   input wire logic short_sync_mode_in, // High selects short-sync mode.
   input wire logic serial_audio_input_in, // Serial audio data.
   input wire logic frame_sync_in, // Word clock or frame sync.
   output logic output_valid_out, // High while outputs are valid.
   output logic settings_default_out, // High while settings are held at default.
   output logic clock_master_out, // Latched master selection.
   output pwm_seq_pkg::sample_s sample_out, // Last delivered audio word.
   output logic sample_strobe_out // One-cycle pulse per new word arriving while valid is high.
);
   import pwm_seq_pkg::*;

   // Refuse delays the counter cannot hold or that are zero.
   if (LONG_DELAY_CYC < 1 || LONG_DELAY_CYC > LONG_MAX_CYC ||
       SHORT_DELAY_CYC < 1 || ERR_SHORT_CYC < 1 ||
       ERR_LONG_CYC < 1 || ERR_LONG_CYC >= (1 << CNT_W) ||
       SHORT_DELAY_CYC >= (1 << CNT_W) || ERR_SHORT_CYC >= (1 << CNT_W) ||
       SYNC_DEPTH + 1 >= ORDER_GAP_MCLK) begin : g_bad_param
      $error("delay parameters out of range");
   end

   ctl_pins_s ctl_meta_r, ctl_s_r;
   seq_state_e state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, tgt_r, tgt_nxt;
   logic long_r, valid_r, master_r;
   logic tog_meta_r, tog_s_r, tog_d_r, strobe_r;
   sample_s sample_r;
   sample_s link_word;
   logic link_tog;

   // Two-stage synchroniser for the controller pins.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctl_meta_r <= '0;
         ctl_s_r <= '0;
      end else begin
         ctl_meta_r <= ctl_pins_in;
         ctl_s_r <= ctl_meta_r;
      end
   end

   // Decoded pin levels after synchronisation.
   wire rst_act = ~ctl_s_r.dev_reset_n;
   wire pwrdn_act = ~ctl_s_r.power_down_request_n;
   wire err_act = ~ctl_s_r.error_recovery_request_n;
   wire held = rst_act | pwrdn_act;
   wire cnt_done = (cnt_r == tgt_r - 1'b1);
   wire err_low_done = (cnt_r == CNT_W'(ERR_LOW_CYC - 1));

   // Delay targets for each recovery kind.
   wire [CNT_W-1:0] tgt_reset = long_r ? CNT_W'(LONG_DELAY_CYC) : CNT_W'(SHORT_DELAY_CYC);
   wire [CNT_W-1:0] tgt_err = ctl_s_r.err_delay_long ? CNT_W'(ERR_LONG_CYC) :
                              CNT_W'(ERR_SHORT_CYC);

   // Next state: reset or power-down overrides everything else.
   always_comb begin
      state_nxt = state_r;
      tgt_nxt = tgt_r;
      if (held) begin
         state_nxt = ST_HELD;
      end else begin
         case (state_r)
            ST_HELD: begin
               tgt_nxt = tgt_reset;
               state_nxt = err_act ? ST_ERR_HOLD : ST_DELAY;
            end
            ST_RUN: begin
               if (err_act) begin
                  state_nxt = ST_ERR_LOW;
               end
            end
            ST_ERR_LOW: begin
               if (err_low_done) begin
                  state_nxt = ST_ERR_HOLD;
               end
            end
            ST_ERR_HOLD: begin
               if (!err_act) begin
                  tgt_nxt = tgt_err;
                  state_nxt = ST_DELAY;
               end
            end
            ST_DELAY: begin
               if (err_act) begin
                  state_nxt = ST_ERR_HOLD;
               end else if (cnt_done) begin
                  state_nxt = ST_RUN;
               end
            end
            default: begin
               state_nxt = ST_HELD;
            end
         endcase
      end
   end

   // Valid stays high until the error low delay has run out.
   wire valid_nxt = (state_nxt == ST_RUN) || (state_nxt == ST_ERR_LOW);

   // Sequencer state, delay counter and outputs.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_r <= ST_HELD;
         cnt_r <= '0;
         tgt_r <= '0;
         valid_r <= VALID_RST;
      end else begin
         state_r <= state_nxt;
         tgt_r <= tgt_nxt;
         cnt_r <= (state_nxt != state_r) ? '0 : cnt_r + 1'b1;
         valid_r <= valid_nxt;
      end
   end

   // Release order decides long or short recovery; the controller's
   // 16-clock gap keeps the two releases apart after synchronising.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         long_r <= 1'b0;
      end else if (!rst_act && pwrdn_act) begin
         long_r <= 1'b1;
      end else if (rst_act && !pwrdn_act) begin
         long_r <= 1'b0;
      end
   end

   // Master selection follows its pin only while reset is asserted.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         master_r <= MASTER_RST;
      end else if (rst_act) begin
         master_r <= ctl_s_r.clock_master_sel;
      end
   end

   // Serial capture on the bit clock domain.
   serial_bit_capture u_capture (
      .bit_clk_in(bit_clk_in),
      .resetn_in(resetn_in),
      .short_sync_mode_in(short_sync_mode_in),
      .serial_audio_input_in(serial_audio_input_in),
      .frame_sync_in(frame_sync_in),
      .word_out(link_word),
      .word_tog_out(link_tog)
   );

   // Word toggle crossing; the held word is copied once its toggle settles, if valid is high.
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tog_meta_r <= 1'b0;
         tog_s_r <= 1'b0;
         tog_d_r <= 1'b0;
         strobe_r <= 1'b0;
         sample_r <= '0;
      end else begin
         tog_meta_r <= link_tog;
         tog_s_r <= tog_meta_r;
         tog_d_r <= tog_s_r;
         strobe_r <= (tog_s_r ^ tog_d_r) & valid_r;
         if ((tog_s_r ^ tog_d_r) && valid_r) begin
            sample_r <= link_word;
         end
      end
   end

   assign output_valid_out = valid_r;
   assign settings_default_out = rst_act;
   assign clock_master_out = master_r;
   assign sample_out = sample_r;
   assign sample_strobe_out = strobe_r;

   // Assertion bounds, in cycles.
   localparam int VLOW_HI = 3;
   localparam int ERRL_HI = 820;

   // Valid drops within three cycles of reset or power-down.
   property p_held_low;
      @(posedge sys_clk_in) disable iff (!resetn_in)
         held |-> ##[1:VLOW_HI] !valid_r;
   endproperty
   a_held_low: assert property (p_held_low) else $error("valid high while held");

   // Long recovery: valid rises after exactly the long delay.
   property p_long_delay;
      @(posedge sys_clk_in) disable iff (!resetn_in)
         ($rose(valid_r) && tgt_r == CNT_W'(LONG_DELAY_CYC))
         |-> $past(cnt_r) == CNT_W'(LONG_DELAY_CYC - 1);
   endproperty
   a_long_delay: assert property (p_long_delay) else $error("long delay wrong");

   // Short recovery: a reset release in the short order loads the short delay target.
   property p_short_delay;
      @(posedge sys_clk_in) disable iff (!resetn_in)
         (state_r == ST_HELD && !held && !err_act && !long_r)
         |=> (tgt_r == CNT_W'(SHORT_DELAY_CYC)) && !valid_r [*2];
   endproperty
   a_short_delay: assert property (p_short_delay) else $error("short delay wrong");

   // Error recovery delay follows the select pin.
   property p_err_delay;
      @(posedge sys_clk_in) disable iff (!resetn_in)
         (state_r == ST_ERR_HOLD && !err_act && !held)
         |=> tgt_r == ($past(ctl_s_r.err_delay_long) ? CNT_W'(ERR_LONG_CYC) :
                       CNT_W'(ERR_SHORT_CYC));
   endproperty
   a_err_delay: assert property (p_err_delay) else $error("error delay select wrong");

   // An error request takes valid low after 6 us and within 47 us.
   // Reset or power-down overrides the error timing, so it ends the attempt.
   property p_err_low;
      @(posedge sys_clk_in) disable iff (!resetn_in || held)
         (state_r == ST_RUN && err_act && !held)
         |=> valid_r [*8] ##112 valid_r ##[1:ERRL_HI] !valid_r;
   endproperty
   a_err_low: assert property (p_err_low) else $error("error low timing wrong");

   // No re-initialisation while the error request is held.
   property p_err_hold;
      @(posedge sys_clk_in) disable iff (!resetn_in)
         (err_act && state_r != ST_RUN && state_r != ST_ERR_LOW) |=> !$rose(valid_r);
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("valid rose under error request");

   // Master selection is frozen outside reset.
   property p_master_frozen;
      @(posedge sys_clk_in) disable iff (!resetn_in)
         !rst_act |=> $stable(master_r);
   endproperty
   a_master_frozen: assert property (p_master_frozen) else $error("master changed");

   // Coverage of the main recovery paths.
   c_long: cover property (@(posedge sys_clk_in) disable iff (!resetn_in)
      $rose(valid_r) && tgt_r == CNT_W'(LONG_DELAY_CYC));
   c_short: cover property (@(posedge sys_clk_in) disable iff (!resetn_in)
      $rose(valid_r) && tgt_r == CNT_W'(SHORT_DELAY_CYC));
   c_err: cover property (@(posedge sys_clk_in) disable iff (!resetn_in)
      state_r == ST_ERR_HOLD ##1 state_r == ST_DELAY);

endmodule
`default_nettype wire

// ==== verif/pwm_ctl_partner.sv ====
// Model of the system controller and serial audio source.
// Assumes the bench calls its tasks; pins move on the master clock edge.
`timescale 1ns/1ns
`default_nettype none
module pwm_ctl_partner (
   input wire logic sys_clk_in, // Master clock.
   output pwm_seq_pkg::ctl_pins_s pins_out, // Controller pins.
   output logic bit_clk_out, // Bit clock, still between frames.
   output logic short_mode_out, // Short-sync selection.
   output logic sdata_out, // Serial audio data.
   output logic fsync_out // Frame sync.
);
   import pwm_seq_pkg::*;
   int cyc = 0;
   int t0 = 0;
   // Idle levels: device in reset and powered down, no error request.
   initial begin
      pins_out = 5'h04;
      bit_clk_out = 1'b0;
      short_mode_out = 1'b0;
      sdata_out = 1'b0;
      fsync_out = 1'b0;
   end
   // Cycle count that stamps every pin change.
   always @(posedge sys_clk_in) cyc <= cyc + 1;
   // Moves one pin on an edge; bit 4 reset, 3 power-down, 2 error, 1 master, 0 delay.
   task automatic set_pin(input int idx, input logic v);
      @(posedge sys_clk_in);
      pins_out[idx] <= v;
      t0 = cyc;
   endtask
   // Reset pin released first, power-down request after the gap.
   task automatic long_rec();
      set_pin(4, 1'b1);
      repeat (ORDER_GAP_MCLK) @(posedge sys_clk_in);
      set_pin(3, 1'b1);
   endtask
   // Power-down request released first, reset pin after the gap.
   task automatic short_rec();
      set_pin(3, 1'b1);
      repeat (ORDER_GAP_MCLK) @(posedge sys_clk_in);
      set_pin(4, 1'b1);
   endtask
   // One bit period; short mode moves data midway through the high phase,
   // so neither bit clock edge sees it change.
   task automatic bit_cycle(input logic d, input logic s);
      if (!short_mode_out) sdata_out = d;
      #40 bit_clk_out = 1'b1;
      #20;
      if (short_mode_out) begin
         sdata_out = d;
         fsync_out = s;
      end
      #20 bit_clk_out = 1'b0;
   endtask
   // Sends four lead bits, one word MSB first, then the boundary.
   task automatic send_word(input logic mode, input logic [31:0] d);
      short_mode_out = mode;
      repeat (4) bit_cycle(1'b0, 1'b0);
      for (int i = 31; i >= 0; i--) bit_cycle(d[i], 1'b0);
      if (mode) begin
         bit_cycle(~d[0], 1'b1);
         bit_cycle(d[0], 1'b0);
      end else begin
         fsync_out = ~fsync_out;
         bit_cycle(~d[0], 1'b0);
      end
      // A released data line shows the inverse of its last bit.
      sdata_out = ~sdata_out;
   endtask
endmodule
`default_nettype wire

// ==== verif/pwm_audio_powerdown_recovery_seq_tb.sv ====
// Self-checking bench for the recovery sequencer and serial intake.
// Assumes shortened delay parameters; expected windows derive from them.
`timescale 1ns/1ns
`default_nettype none
module pwm_audio_powerdown_recovery_seq_tb;
   import pwm_seq_pkg::*;
   localparam int L_CYC = 200;
   localparam int S_CYC = 40;
   localparam int ES_CYC = 40;
   localparam int EL_CYC = 50;
   logic sys_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   ctl_pins_s ctl_pins;
   logic bit_clk, short_mode, sdata, fsync;
   logic valid, settings_default, clock_master, strobe;
   sample_s sample;
   int miscompares = 0;
   int num_checks = 0;
   int seed = 32'hA7B6;
   int win_lo[$];
   int win_hi[$];
   logic [33:0] word_q[$];
   logic valid_prev = 1'b0;
   logic [31:0] w;
   int lat;

   // Master clock, 50 ns period.
   initial forever #25 sys_clk_in = ~sys_clk_in;

   pwm_audio_powerdown_recovery_seq #(.LONG_DELAY_CYC(L_CYC), .SHORT_DELAY_CYC(S_CYC),
      .ERR_SHORT_CYC(ES_CYC), .ERR_LONG_CYC(EL_CYC)) pwm_audio_powerdown_recovery_seq_i (
      .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .ctl_pins_in(ctl_pins),
      .bit_clk_in(bit_clk), .short_sync_mode_in(short_mode),
      .serial_audio_input_in(sdata), .frame_sync_in(fsync), .output_valid_out(valid),
      .settings_default_out(settings_default), .clock_master_out(clock_master),
      .sample_out(sample), .sample_strobe_out(strobe));

   pwm_ctl_partner pwm_ctl_partner_i (.sys_clk_in(sys_clk_in), .pins_out(ctl_pins),
      .bit_clk_out(bit_clk), .short_mode_out(short_mode), .sdata_out(sdata),
      .fsync_out(fsync));

   // Compares one value and counts the outcome.
   task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Notes the window in which the next valid edge must land.
   task automatic expect_edge(input int lo, input int hi);
      win_lo.push_back(lo);
      win_hi.push_back(hi);
   endtask

   // Waits a bounded time for valid to reach a level.
   task automatic wait_valid(input logic v, input int bound);
      int n;
      n = 0;
      while (valid !== v && n < bound) begin
         @(posedge sys_clk_in);
         n++;
      end
      if (valid !== v) begin
         miscompares++;
         finish_test();
      end
   endtask

   // Every valid edge is timed against the oldest noted window.
   always @(posedge sys_clk_in) begin
      if (resetn_in && valid !== valid_prev) begin
         lat = pwm_ctl_partner_i.cyc - pwm_ctl_partner_i.t0;
         if (win_lo.size() == 0) check("valid_edge", 33'h0, 33'h1);
         else begin
            check("valid_delay", {32'h0, lat >= win_lo[0] && lat <= win_hi[0]}, 33'h1);
            void'(win_lo.pop_front());
            void'(win_hi.pop_front());
         end
      end
      valid_prev <= valid;
   end

   // Every delivered word is compared with the oldest noted word.
   always @(posedge sys_clk_in) begin
      if (strobe === 1'b1) begin
         if (word_q.size() == 0) check("sample_extra", 33'h0, 33'h1);
         else begin
            if (word_q[0][33]) check("sample_word", sample, word_q[0][32:0]);
            else check("sample_data", {1'b0, sample.data}, {1'b0, word_q[0][31:0]});
            void'(word_q.pop_front());
         end
      end
   end

   // Main sequence.
   initial begin
      repeat (2) @(posedge sys_clk_in);
      resetn_in <= 1'b1;
      pwm_ctl_partner_i.long_rec();
      expect_edge(L_CYC + 2, L_CYC + 6);
      wait_valid(1'b1, L_CYC + 40);
      check("defaults_run", {32'h0, settings_default}, 33'h0);
      $display("test long recovery done");
      w = $random(seed);
      word_q.push_back({2'h0, w});
      pwm_ctl_partner_i.send_word(1'b1, w);
      w = $random(seed);
      word_q.push_back({2'h3, w});
      pwm_ctl_partner_i.send_word(1'b0, w);
      repeat (10) @(posedge sys_clk_in);
      check("words_left", {32'h0, word_q.size() == 0}, 33'h1);
      $display("test serial capture done");
      for (int e = 0; e < 2; e++) begin
         pwm_ctl_partner_i.set_pin(0, e[0]);
         pwm_ctl_partner_i.set_pin(2, 1'b0);
         expect_edge(ERR_LOW_CYC, ERR_LOW_CYC + 8);
         wait_valid(1'b0, 200);
         pwm_ctl_partner_i.set_pin(2, 1'b1);
         expect_edge((e ? EL_CYC : ES_CYC) + 2, (e ? EL_CYC : ES_CYC) + 8);
         wait_valid(1'b1, 200);
         $display("test error recovery done");
      end
      pwm_ctl_partner_i.set_pin(1, 1'b1);
      repeat (8) @(posedge sys_clk_in);
      check("master_in_run", {32'h0, clock_master}, 33'h0);
      pwm_ctl_partner_i.set_pin(3, 1'b0);
      pwm_ctl_partner_i.set_pin(4, 1'b0);
      expect_edge(1, 20);
      wait_valid(1'b0, 40);
      repeat (4) @(posedge sys_clk_in);
      check("master_latched", {32'h0, clock_master}, 33'h1);
      check("defaults_held", {32'h0, settings_default}, 33'h1);
      pwm_ctl_partner_i.short_rec();
      expect_edge(S_CYC + 2, S_CYC + 6);
      wait_valid(1'b1, S_CYC + 40);
      $display("test short recovery done");
      pwm_ctl_partner_i.set_pin(2, 1'b0);
      pwm_ctl_partner_i.set_pin(4, 1'b0);
      expect_edge(1, 20);
      wait_valid(1'b0, 40);
      pwm_ctl_partner_i.set_pin(4, 1'b1);
      repeat (300) @(posedge sys_clk_in);
      check("valid_held_off", {32'h0, valid}, 33'h0);
      pwm_ctl_partner_i.set_pin(2, 1'b1);
      expect_edge(EL_CYC + 2, EL_CYC + 8);
      wait_valid(1'b1, 200);
      $display("test held start done");
      finish_test();
   end
endmodule
`default_nettype wire
